// File: design/dgp_gpio.sv
// Two general purpose I/O ports with an APB register interface.
`timescale 1ns/10ps
`default_nettype none

module dgp_gpio
	import dgp_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [31:0] prdata,
	input  wire logic        irq_function_enable,
	input  wire logic [1:0]  oscillator_mode,
	input  wire logic        wakeup_request_latch,
	input  wire logic        quadrupled_bus_clock,
	output logic             branch_irq_level_high,
	input  wire logic [5:0]  first_port_pin_in,
	output logic      [5:0]  first_port_pin_out,
	output logic      [5:0]  first_port_pin_oe,
	output logic      [5:0]  first_port_pullup_on,
	input  wire logic [7:0]  second_port_pin_in,
	output logic      [7:0]  second_port_pin_out,
	output logic      [7:0]  second_port_pin_oe,
	output logic      [7:0]  second_port_pullup_on
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [5:0]  first_data;
		logic [5:0]  first_dir;
		logic [5:0]  first_pullup;
		logic        osc_out_clock_enable;
		logic [7:0]  second_data;
		logic [7:0]  second_dir;
		logic [7:0]  second_pullup;
		logic [5:0]  first_sync1;
		logic [5:0]  first_sync2;
		logic [7:0]  second_sync1;
		logic [7:0]  second_sync2;
		logic [31:0] rdata;
	} dgp_state_t;

	dgp_state_t st;
	dgp_state_t next_st;

	logic        setup_phase;
	logic        write_access;
	logic        addr_mapped;
	logic        osc_clock_mode;
	logic        osc_owns_pin;
	logic        clock_on_pin;
	logic [5:0]  first_gpio_mask;
	logic [7:0]  first_read;
	logic [7:0]  second_read;
	logic [31:0] read_word;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	assign setup_phase  = psel && !penable;
	assign write_access = psel && penable && pwrite;

	always_comb begin
		case (paddr)
			DGP_FIRST_DATA_ADDR,
			DGP_FIRST_DIR_ADDR,
			DGP_FIRST_PULLUP_ADDR,
			DGP_SECOND_DATA_ADDR,
			DGP_SECOND_DIR_ADDR,
			DGP_SECOND_PULLUP_ADDR: addr_mapped = 1'b1;
			default: addr_mapped = 1'b0;
		endcase
	end

	// The slave never stretches the access phase.
	assign pready  = penable;
	assign pslverr = psel && penable && !addr_mapped;
	assign prdata  = st.rdata;

	// ------------------------------------------------------------
	// Oscillator pin ownership
	// ------------------------------------------------------------
	// Only internal and RC modes look at the enable bit.
	assign osc_clock_mode = (oscillator_mode == DGP_OSC_INTERNAL) || (oscillator_mode == DGP_OSC_RC);
	assign clock_on_pin   = osc_clock_mode && st.osc_out_clock_enable;
	// In crystal mode the pin belongs to the amplifier, so the port lets go of it.
	assign osc_owns_pin   = clock_on_pin || (oscillator_mode == DGP_OSC_CRYSTAL);

	always_comb begin
		first_gpio_mask = 6'h3f;
		first_gpio_mask[DGP_OSC_PIN_BIT] = !osc_owns_pin;
	end

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	always_comb begin
		first_port_pin_out = st.first_data;
		first_port_pin_oe  = st.first_dir & first_gpio_mask;
		first_port_pin_oe[DGP_IRQ_PIN_BIT] = 1'b0;
		// The clock is muxed straight onto the pin; a flop would halve it.
		if (clock_on_pin) begin
			first_port_pin_out[DGP_OSC_PIN_BIT] = quadrupled_bus_clock;
			first_port_pin_oe[DGP_OSC_PIN_BIT]  = 1'b1;
		end
		first_port_pullup_on = st.first_pullup & ~st.first_dir & first_gpio_mask;
	end

	assign second_port_pin_out   = st.second_data;
	assign second_port_pin_oe    = st.second_dir;
	assign second_port_pullup_on = st.second_pullup & ~st.second_dir;

	// The branch instructions see the pin only while the irq function owns it.
	assign branch_irq_level_high = irq_function_enable ? st.first_sync2[DGP_IRQ_PIN_BIT] : 1'b1;

	// ------------------------------------------------------------
	// Read values
	// ------------------------------------------------------------
	always_comb begin
		first_read = 8'h00;
		for (int i = 0; i < DGP_FIRST_WIDTH; i++) begin
			first_read[i] = st.first_dir[i] ? st.first_data[i] : st.first_sync2[i];
		end
		first_read[DGP_IRQ_PIN_BIT] = irq_function_enable ? 1'b0 : st.first_sync2[DGP_IRQ_PIN_BIT];
		first_read[DGP_WAKEUP_BIT]  = wakeup_request_latch;
		second_read = (st.second_dir & st.second_data) | (~st.second_dir & st.second_sync2);
	end

	always_comb begin
		read_word = 32'h0000_0000;
		case (paddr)
			DGP_FIRST_DATA_ADDR:   read_word[7:0] = first_read;
			DGP_FIRST_DIR_ADDR:    read_word[5:0] = st.first_dir;
			DGP_FIRST_PULLUP_ADDR: begin
				read_word[5:0] = st.first_pullup;
				read_word[DGP_OSC_ENABLE_BIT] = st.osc_out_clock_enable;
			end
			DGP_SECOND_DATA_ADDR:   read_word[7:0] = second_read;
			DGP_SECOND_DIR_ADDR:    read_word[7:0] = st.second_dir;
			DGP_SECOND_PULLUP_ADDR: read_word[7:0] = st.second_pullup;
			default: read_word = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		// First stage feeds only the second stage.
		next_st.first_sync1  = first_port_pin_in;
		next_st.first_sync2  = st.first_sync1;
		next_st.second_sync1 = second_port_pin_in;
		next_st.second_sync2 = st.second_sync1;
		if (setup_phase && !pwrite) begin
			next_st.rdata = read_word;
		end
		if (write_access) begin
			case (paddr)
				// Latches take the write whatever the direction.
				DGP_FIRST_DATA_ADDR: next_st.first_data = pwdata[5:0];
				DGP_FIRST_DIR_ADDR:  next_st.first_dir  = pwdata[5:0];
				DGP_FIRST_PULLUP_ADDR: begin
					next_st.first_pullup         = pwdata[5:0];
					next_st.osc_out_clock_enable = pwdata[DGP_OSC_ENABLE_BIT];
				end
				DGP_SECOND_DATA_ADDR:   next_st.second_data   = pwdata[7:0];
				DGP_SECOND_DIR_ADDR:    next_st.second_dir    = pwdata[7:0];
				DGP_SECOND_PULLUP_ADDR: next_st.second_pullup = pwdata[7:0];
				default: next_st.rdata = st.rdata;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Data latches are deliberately left out of the reset branch.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st.first_dir            <= DGP_FIRST_DIR_RESET;
			st.first_pullup         <= DGP_FIRST_PULLUP_RESET;
			st.osc_out_clock_enable <= DGP_OSC_ENABLE_RESET;
			st.second_dir           <= DGP_SECOND_DIR_RESET;
			st.second_pullup        <= DGP_SECOND_PULLUP_RESET;
			st.first_sync1          <= 6'h00;
			st.first_sync2          <= 6'h00;
			st.second_sync1         <= 8'h00;
			st.second_sync2         <= 8'h00;
			st.rdata                <= 32'h0000_0000;
		end else begin
			st <= next_st;
		end
	end

endmodule

`default_nettype wire

// File: inc/dgp_pkg.sv
// Constants and register map of the dual port general purpose I/O block.
package dgp_pkg;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] DGP_FIRST_DATA_ADDR   = 8'h00;
	localparam logic [7:0] DGP_FIRST_DIR_ADDR    = 8'h04;
	localparam logic [7:0] DGP_FIRST_PULLUP_ADDR = 8'h08;
	localparam logic [7:0] DGP_SECOND_DATA_ADDR  = 8'h0c;
	localparam logic [7:0] DGP_SECOND_DIR_ADDR   = 8'h10;
	localparam logic [7:0] DGP_SECOND_PULLUP_ADDR = 8'h14;

	// ------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------
	localparam int DGP_FIRST_WIDTH    = 6;
	localparam int DGP_SECOND_WIDTH   = 8;
	localparam int DGP_IRQ_PIN_BIT    = 2;
	localparam int DGP_OSC_PIN_BIT    = 4;
	localparam int DGP_WAKEUP_BIT     = 6;
	localparam int DGP_OSC_ENABLE_BIT = 7;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [5:0] DGP_FIRST_DIR_RESET    = 6'h00;
	localparam logic [5:0] DGP_FIRST_PULLUP_RESET = 6'h00;
	localparam logic       DGP_OSC_ENABLE_RESET   = 1'b0;
	localparam logic [7:0] DGP_SECOND_DIR_RESET   = 8'h00;
	localparam logic [7:0] DGP_SECOND_PULLUP_RESET = 8'h00;

	// ------------------------------------------------------------
	// Oscillator option codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DGP_OSC_INTERNAL = 2'b00,
		DGP_OSC_EXTCLK   = 2'b01,
		DGP_OSC_RC       = 2'b10,
		DGP_OSC_CRYSTAL  = 2'b11
	} dgp_osc_mode_t;

endpackage

// File: testbench/dgp_board.sv
// Board model that resolves each port pin from the block and an external driver.
`timescale 1ns/10ps
`default_nettype none
module dgp_board #(parameter int W = 8) (
	input  wire logic [W-1:0] oe,
	input  wire logic [W-1:0] drv,
	input  wire logic [W-1:0] pu,
	input  wire logic [W-1:0] ext,
	output logic      [W-1:0] pin
);
	// The external driver is weak, so both the block's buffer and its pullup override it.
	assign pin = (oe & drv) | (~oe & pu) | (~oe & ~pu & ext);
endmodule
`default_nettype wire

// File: testbench/dgp_gpio_sva.sv
// Concurrent checks on the ports of the dual port I/O block.
`timescale 1ns/10ps
`default_nettype none
module dgp_gpio_sva
	import dgp_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        irq_function_enable,
	input wire logic [1:0]  oscillator_mode,
	input wire logic        branch_irq_level_high,
	input wire logic [5:0]  first_port_pin_oe,
	input wire logic [5:0]  first_port_pullup_on,
	input wire logic [7:0]  second_port_pin_out,
	input wire logic [7:0]  second_port_pin_oe,
	input wire logic [7:0]  second_port_pullup_on
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_wr(logic [7:0] a);
		psel && penable && pwrite && paddr == a;
	endsequence
	property p_oe2; first_port_pin_oe[DGP_IRQ_PIN_BIT] == 1'b0; endproperty
	property p_brq; !irq_function_enable |-> branch_irq_level_high; endproperty
	property p_pua; (first_port_pullup_on & first_port_pin_oe) == 6'h00; endproperty
	property p_pub; (second_port_pullup_on & second_port_pin_oe) == 8'h00; endproperty
	property p_rst; $rose(rst_n) |-> first_port_pin_oe == 6'h00 && second_port_pin_oe == 8'h00; endproperty
	property p_dirb; s_wr(DGP_SECOND_DIR_ADDR) |=> second_port_pin_oe == $past(pwdata[7:0]); endproperty
	property p_datb; s_wr(DGP_SECOND_DATA_ADDR) |=> second_port_pin_out == $past(pwdata[7:0]); endproperty
	property p_crystal_option;
		oscillator_mode == DGP_OSC_CRYSTAL |-> !first_port_pin_oe[4] && !first_port_pullup_on[4];
	endproperty
	a_oe2: assert property (p_oe2) else $error("pin two driven");
	a_brq: assert property (p_brq) else $error("branch sense not high");
	a_pua: assert property (p_pua) else $error("first pullup on output");
	a_pub: assert property (p_pub) else $error("second pullup on output");
	a_rst: assert property (p_rst) else $error("direction not cleared");
	a_dirb: assert property (p_dirb) else $error("second enable wrong");
	a_datb: assert property (p_datb) else $error("second latch wrong");
	a_crystal_option: assert property (p_crystal_option) else $error("crystal pin used");
endmodule
bind dgp_gpio dgp_gpio_sva dgp_gpio_sva_inst (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
	.irq_function_enable, .oscillator_mode, .branch_irq_level_high, .first_port_pin_oe,
	.first_port_pullup_on, .second_port_pin_out, .second_port_pin_oe, .second_port_pullup_on);
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the dual port I/O block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import dgp_pkg::*;
	logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0, ext_b = 0, lb, db, b_in, b_out, b_oe, b_pu;
	logic [31:0] pwdata = 0, prdata;
	logic        pready, pslverr, brq, irq_en = 0, wake = 0, qclk = 0;
	logic [1:0]  osc_mode = 0;
	logic [5:0]  ext_a = 0, a_in, a_out, a_oe, a_pu;
	logic [31:0] exp_q[$];
	int          mismatches = 0, cmp_count = 0, seed = 32, i;
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) qclk <= ~qclk;
	dgp_gpio dgp_gpio_inst (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
		.prdata, .irq_function_enable(irq_en), .oscillator_mode(osc_mode), .wakeup_request_latch(wake),
		.quadrupled_bus_clock(qclk), .branch_irq_level_high(brq), .first_port_pin_in(a_in),
		.first_port_pin_out(a_out), .first_port_pin_oe(a_oe), .first_port_pullup_on(a_pu),
		.second_port_pin_in(b_in), .second_port_pin_out(b_out), .second_port_pin_oe(b_oe),
		.second_port_pullup_on(b_pu));
	dgp_board #(.W(6)) dgp_board_a_inst (.oe(a_oe), .drv(a_out), .pu(a_pu), .ext(ext_a), .pin(a_in));
	dgp_board #(.W(8)) dgp_board_b_inst (.oe(b_oe), .drv(b_out), .pu(b_pu), .ext(ext_b), .pin(b_in));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) exp_q.push_back(e);
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Read data is judged when the master takes it, against the oldest noted expectation.
	always @(posedge sys_clk) if (psel && penable && !pwrite && pready === 1'b1) chk(prdata, exp_q.pop_front());
	initial begin
		#200000;
		mismatches++;
		report_and_stop();
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		apb(0, DGP_FIRST_DIR_ADDR, 0, 32'h0);
		apb(0, DGP_SECOND_DIR_ADDR, 0, 32'h0);
		apb(0, 8'h18, 0, 32'h0);
		for (i = 0; i < 4; i++) begin
			ext_b <= $random(seed);
			lb = $random(seed);
			db = $random(seed);
			apb(1, DGP_SECOND_DATA_ADDR, {24'h0, lb}, 0);
			apb(1, DGP_SECOND_DIR_ADDR, {24'h0, db}, 0);
			// Pins that just changed direction need two more edges to clear the synchroniser.
			repeat (2) @(posedge sys_clk);
			apb(0, DGP_SECOND_DATA_ADDR, 0, (lb & db) | (ext_b & ~db));
			chk(b_oe, db);
			chk(b_out, lb);
		end
		apb(1, DGP_SECOND_PULLUP_ADDR, 32'hff, 0);
		apb(1, DGP_SECOND_DIR_ADDR, 32'h0f, 0);
		apb(0, DGP_SECOND_PULLUP_ADDR, 0, 32'hff);
		chk(b_pu, 8'hf0);
		apb(1, DGP_SECOND_PULLUP_ADDR, 32'h00, 0);
		chk(b_pu, 8'h00);
		ext_a <= $random(seed);
		wake <= 1'b1;
		irq_en <= 1'b1;
		apb(1, DGP_FIRST_DATA_ADDR, 32'h15, 0);
		apb(1, DGP_FIRST_DIR_ADDR, 32'h3f, 0);
		apb(0, DGP_FIRST_DATA_ADDR, 0, 32'h51);
		chk(a_oe, 6'h3b);
		chk(brq, ext_a[2]);
		irq_en <= 1'b0;
		wake <= 1'b0;
		apb(0, DGP_FIRST_DATA_ADDR, 0, {29'h0, ext_a[2], 2'b01} | 32'h10);
		chk(brq, 1'b1);
		apb(1, DGP_FIRST_DIR_ADDR, 32'h00, 0);
		repeat (2) @(posedge sys_clk);
		apb(0, DGP_FIRST_DATA_ADDR, 0, {26'h0, ext_a});
		apb(1, DGP_FIRST_PULLUP_ADDR, 32'h3f, 0);
		apb(1, DGP_FIRST_DIR_ADDR, 32'h03, 0);
		chk(a_pu, 6'h3c);
		apb(1, DGP_FIRST_PULLUP_ADDR, 32'hbf, 0);
		for (i = 0; i < 4; i++) begin
			osc_mode <= i[1:0];
			@(negedge sys_clk);
			chk(a_oe[4], i[0] == 1'b0);
			chk(a_pu[4], i == 1);
			if (i[0] == 1'b0) chk(a_out[4], qclk);
			@(posedge sys_clk);
		end
		lb = b_out;
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		chk(b_out, lb);
		chk(a_oe, 6'h00);
		apb(0, DGP_SECOND_DIR_ADDR, 0, 32'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
